// [core/spsb_core.sv]
// Purpose: pipelined synchronous memory, two-bit burst counter, APB side port
// Assumes: pins other than output_enable_n synchronous to ref_clk; read_not_write high means read
// Notes:   read words may be copied into a capture FIFO readable over APB
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module spsb_core (
    input  wire logic                            ref_clk,            // 40 MHz clock
    input  wire logic                            nrst,               // sync reset, low
    input  wire logic                            ce,                 // global clock enable
    input  wire logic [spsb_pkg::ADDR_W-1:0]     address,            // word address
    input  wire logic                            read_not_write,     // 1 read, 0 write
    input  wire logic                            advance_or_load,    // 1 advance, 0 load
    input  wire logic                            select_low_a,       // select, active low
    input  wire logic                            select_high,        // select, active high
    input  wire logic                            select_low_b,       // select, active low
    input  wire logic [spsb_pkg::BYTES-1:0]      byte_write_strobe_n, // lane writes, low
    input  wire logic                            clock_enable_n,     // pin enable, low
    input  wire logic                            burst_order_select, // 1 interleaved
    input  wire logic                            output_enable_n,    // async drive gate
    input  wire logic [spsb_pkg::DATA_W-1:0]     data_in,            // bus data in
    output logic [spsb_pkg::DATA_W-1:0]          data_out,           // bus data out
    output logic                                 data_oe,            // bus drive enable
    input  wire logic                            psel,               // APB select
    input  wire logic                            penable,            // APB enable
    input  wire logic                            pwrite,             // APB direction
    input  wire logic [spsb_pkg::PADDR_W-1:0]    paddr,              // APB address
    input  wire logic [spsb_pkg::DATA_W-1:0]     pwdata,             // APB write data
    output logic [spsb_pkg::DATA_W-1:0]          prdata,             // APB read data
    output logic                                 pready,             // APB ready
    output logic                                 pslverr,            // APB error
    output logic                                 capture_ready       // capture FIFO space
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [spsb_pkg::DATA_W-1:0]  mem_reg [0:spsb_pkg::MEM_DEPTH-1];
    logic                         bst_active_reg;
    logic                         bst_write_reg;
    logic [spsb_pkg::ADDR_W-1:0]  bst_base_reg;
    logic [spsb_pkg::BCNT_W-1:0]  bst_cnt_reg;
    spsb_pkg::spsb_op_e           s1_op_reg;
    logic [spsb_pkg::ADDR_W-1:0]  s1_addr_reg;
    logic [spsb_pkg::BYTES-1:0]   s1_bw_reg;
    spsb_pkg::spsb_op_e           s2_op_reg;
    logic [spsb_pkg::ADDR_W-1:0]  s2_addr_reg;
    logic [spsb_pkg::BYTES-1:0]   s2_bw_reg;
    logic [spsb_pkg::DATA_W-1:0]  dout_reg;
    logic                         drive_reg;
    logic [1:0]                   ctrl_reg;
    logic [spsb_pkg::DATA_W-1:0]  prdata_reg;
    logic                         pready_reg;
    logic                         pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // command decode
    wire                          act;
    wire                          selected;
    wire                          is_load;
    wire                          is_burst;
    wire [spsb_pkg::BCNT_W-1:0]   cnt_inc;
    wire [spsb_pkg::BCNT_W-1:0]   start_low;
    wire [spsb_pkg::BCNT_W-1:0]   low_il;
    wire [spsb_pkg::BCNT_W-1:0]   low_lin;
    wire [spsb_pkg::BCNT_W-1:0]   burst_low;
    wire [spsb_pkg::ADDR_W-1:0]   burst_addr;
    spsb_pkg::spsb_op_e           s1_op_next;
    wire [spsb_pkg::ADDR_W-1:0]   s1_addr_next;
    wire [spsb_pkg::BYTES-1:0]    s1_bw_next;
    wire                          bst_active_next;

    assign act = ce & ~clock_enable_n;
    assign selected = ~select_low_a & select_high & ~select_low_b
                    & ctrl_reg[spsb_pkg::CTRL_RUN];
    assign is_load  = ~advance_or_load & selected;
    assign is_burst = advance_or_load & bst_active_reg;

    assign cnt_inc   = bst_cnt_reg + spsb_pkg::BCNT_ONE;
    assign start_low = bst_base_reg[spsb_pkg::BCNT_W-1:0];
    assign low_il    = start_low ^ cnt_inc;
    assign low_lin   = start_low + cnt_inc;
    assign burst_low = burst_order_select ? low_il : low_lin;
    assign burst_addr = {bst_base_reg[spsb_pkg::ADDR_W-1:spsb_pkg::BCNT_W], burst_low};

    assign s1_op_next = is_load  ? (read_not_write ? spsb_pkg::OP_READ : spsb_pkg::OP_WRITE)
                      : is_burst ? (bst_write_reg ? spsb_pkg::OP_WRITE : spsb_pkg::OP_READ)
                      : spsb_pkg::OP_IDLE;
    assign s1_addr_next = is_load ? address : burst_addr;
    assign s1_bw_next   = ~byte_write_strobe_n;
    assign bst_active_next = is_load | (advance_or_load & bst_active_reg);

    ////////////////////////////////////////////////////////////////////////////
    // burst counter and address stage
    // rising-edge sampling
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bst_active_reg <= 1'b0;
            bst_write_reg  <= 1'b0;
            bst_base_reg   <= '0;
            bst_cnt_reg    <= spsb_pkg::BCNT_ZERO;
        end else if (act) begin
            bst_active_reg <= bst_active_next;
            if (is_load) begin
                bst_write_reg <= ~read_not_write;
                bst_base_reg  <= address;
                bst_cnt_reg   <= spsb_pkg::BCNT_ZERO;
            end else if (is_burst) begin
                bst_cnt_reg <= cnt_inc;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s1_op_reg   <= spsb_pkg::OP_IDLE;
            s1_addr_reg <= '0;
            s1_bw_reg   <= '0;
            s2_op_reg   <= spsb_pkg::OP_IDLE;
            s2_addr_reg <= '0;
            s2_bw_reg   <= '0;
        end else if (act) begin
            s1_op_reg   <= s1_op_next;
            s1_addr_reg <= s1_addr_next;
            s1_bw_reg   <= s1_bw_next;
            s2_op_reg   <= s1_op_reg;
            s2_addr_reg <= s1_addr_reg;
            s2_bw_reg   <= s1_bw_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data stage
    logic drive_next;
    logic wr_go;

    always_comb begin
        case (s2_op_reg)
            spsb_pkg::OP_READ: begin
                drive_next = 1'b1;
                wr_go      = 1'b0;
            end
            spsb_pkg::OP_WRITE: begin
                drive_next = 1'b0;
                wr_go      = 1'b1;
            end
            default: begin
                drive_next = 1'b0;
                wr_go      = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dout_reg  <= '0;
            drive_reg <= 1'b0;
        end else if (act) begin
            drive_reg <= drive_next;
            if (drive_next) begin
                dout_reg <= mem_reg[s2_addr_reg];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (act && wr_go) begin
            for (int b = 0; b < spsb_pkg::BYTES; b++) begin
                if (s2_bw_reg[b]) begin
                    mem_reg[s2_addr_reg][b*8 +: 8] <= data_in[b*8 +: 8];
                end
            end
        end
    end

    assign data_out = dout_reg;
    assign data_oe  = drive_reg & ~output_enable_n;

    ////////////////////////////////////////////////////////////////////////////
    // capture FIFO of read words
    wire                               cap_valid;
    wire                               cap_out_valid;
    wire [spsb_pkg::DATA_W-1:0]        cap_out_data;
    wire [spsb_pkg::FIFO_CNT_W-1:0]    cap_level;
    wire                               cap_pop;

    assign cap_valid = act & drive_next & ctrl_reg[spsb_pkg::CTRL_CAPTURE];

    spsb_fifo #(
        .WIDTH (spsb_pkg::DATA_W),
        .DEPTH (spsb_pkg::FIFO_DEPTH),
        .CNT_W (spsb_pkg::FIFO_CNT_W)
    ) u_capture (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .ce        (ce),
        .in_valid  (cap_valid),
        .in_ready  (capture_ready),
        .in_data   (mem_reg[s2_addr_reg]),
        .out_valid (cap_out_valid),
        .out_ready (cap_pop),
        .out_data  (cap_out_data),
        .level     (cap_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    wire                          apb_access;
    wire                          hit_ctrl;
    wire                          hit_stat;
    wire                          hit_fifo;
    wire                          hit_any;
    wire [spsb_pkg::DATA_W-1:0]   status_word;
    wire [spsb_pkg::DATA_W-1:0]   rd_mux;

    assign apb_access = psel & penable & ~pready_reg;
    assign hit_ctrl   = (paddr == spsb_pkg::REG_CTRL);
    assign hit_stat   = (paddr == spsb_pkg::REG_STATUS);
    assign hit_fifo   = (paddr == spsb_pkg::REG_FIFO);
    assign hit_any    = hit_ctrl | hit_stat | hit_fifo;
    assign cap_pop    = apb_access & ~pwrite & hit_fifo;

    assign status_word = (spsb_pkg::DATA_W'(bst_active_reg) << spsb_pkg::STAT_ACTIVE)
                       | (spsb_pkg::DATA_W'(bst_write_reg)  << spsb_pkg::STAT_WRITE)
                       | (spsb_pkg::DATA_W'(bst_cnt_reg)    << spsb_pkg::STAT_CNT_LO)
                       | (spsb_pkg::DATA_W'(cap_level)      << spsb_pkg::STAT_LVL_LO);
    assign rd_mux = hit_ctrl ? spsb_pkg::DATA_W'(ctrl_reg)
                  : hit_stat ? status_word
                  : (hit_fifo & cap_out_valid) ? cap_out_data
                  : '0;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_reg    <= spsb_pkg::CTRL_RESET;
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            pready_reg  <= apb_access;
            pslverr_reg <= apb_access & ~hit_any;
            if (apb_access && !pwrite) begin
                prdata_reg <= rd_mux;
            end
            if (apb_access && pwrite && hit_ctrl) begin
                ctrl_reg <= pwdata[1:0];
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_read_latency : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (act && is_load && read_not_write) ##1 act ##1 act |=> drive_reg)
        else $error("load read not driven two edges later");

    a_desel_float : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (act && !advance_or_load && !selected) ##1 act ##1 act |=> !drive_reg)
        else $error("bus still driven after deselect");

    a_freeze_hold : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !act |=> $stable(dout_reg) && $stable(drive_reg) && $stable(bst_cnt_reg))
        else $error("state moved while clock enable inactive");

    a_cnt_wrap : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (act && is_burst) |=> bst_cnt_reg == $past(bst_cnt_reg) + 2'h1)
        else $error("burst counter did not step");

    a_il_order : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (act && is_burst && burst_order_select)
        |=> s1_addr_reg[1:0] == (bst_base_reg[1:0] ^ bst_cnt_reg))
        else $error("interleaved order broken");

    a_lin_order : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (act && is_burst && !burst_order_select)
        |=> s1_addr_reg[1:0] == 2'(bst_base_reg[1:0] + bst_cnt_reg))
        else $error("linear order broken");

    a_dir_kept : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (act && is_burst) |=> (s1_op_reg == spsb_pkg::OP_WRITE) == bst_write_reg)
        else $error("burst direction changed");

    a_sel_gate : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (act && !advance_or_load && select_low_a) |=> s1_op_reg == spsb_pkg::OP_IDLE)
        else $error("operation started while deselected");

    a_burst_gap : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (act && is_burst && !bst_write_reg) ##1 act ##1 act |=> drive_reg)
        else $error("gap in burst read data");

    a_oe_gate : assert property (
        @(posedge ref_clk) disable iff (!nrst)
        output_enable_n |-> !data_oe)
        else $error("drivers on with output enable inactive");

endmodule : spsb_core

// [core/spsb_pkg.sv]
// Purpose: shared constants and types for the pipelined burst memory
// Assumes: 32-bit data, four byte lanes, small flop-based array
// Notes:   APB offsets are byte addresses
package spsb_pkg;

    localparam int ADDR_W     = 6;
    localparam int DATA_W     = 32;
    localparam int BYTES      = 4;
    localparam int MEM_DEPTH  = 64;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_CNT_W = 5;
    localparam int PADDR_W    = 12;
    localparam int BCNT_W     = 2;

    // register map
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_FIFO   = 12'h008;

    // control fields
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_CAPTURE = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // status fields
    localparam int STAT_ACTIVE = 0;
    localparam int STAT_WRITE  = 1;
    localparam int STAT_CNT_LO = 2;
    localparam int STAT_LVL_LO = 4;

    localparam logic [1:0] BCNT_ZERO = 2'h0;
    localparam logic [1:0] BCNT_ONE  = 2'h1;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } spsb_op_e;

endpackage : spsb_pkg

// [core/spsb_fifo.sv]
// Purpose: flop-based FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   in_ready and out_valid come from registers
`timescale 1ns/1ps
module spsb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int CNT_W = 5
) (
    input  wire logic             ref_clk,   // clock
    input  wire logic             nrst,      // sync reset, active low
    input  wire logic             ce,        // clock enable
    input  wire logic             in_valid,  // push request
    output logic                  in_ready,  // not full
    input  wire logic [WIDTH-1:0] in_data,   // push data
    output logic                  out_valid, // not empty
    input  wire logic             out_ready, // pop request
    output logic [WIDTH-1:0]      out_data,  // head word
    output logic [CNT_W-1:0]      level      // words held
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store_reg [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] level_reg;
    logic [CNT_W-1:0] level_next;
    wire              push;
    wire              pop;

    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = store_reg[rd_ptr_reg];
    assign level     = level_reg;
    assign level_next = level_reg + CNT_W'(push) - CNT_W'(pop);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg  <= '0;
            in_ready   <= 1'b1;
            out_valid  <= 1'b0;
        end else if (ce) begin
            if (push) begin
                store_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg            <= wr_ptr_reg + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
            end
            level_reg <= level_next;
            in_ready  <= (level_next != CNT_W'(DEPTH));
            out_valid <= (level_next != '0);
        end
    end

endmodule : spsb_fifo

// [tb/spsb_ctrl_model.sv]
// Purpose: memory controller model driving the burst memory pins
// Assumes: one command per cycle from the bench, held edge to edge
// Notes:   don't-care pins carry inverted or toggling values
`timescale 1ns/1ps
module spsb_ctrl_model (
    input  wire logic        ref_clk,             // clock
    input  wire logic        nrst,                // sync reset, low
    input  wire logic [2:0]  cmd_kind,            // 0 desel 1 rd 2 wr 3 adv 4 hold
    input  wire logic [5:0]  cmd_addr,            // load address or select index
    input  wire logic [31:0] cmd_wdata,           // write word of this command
    output logic [5:0]       address,             // word address
    output logic             read_not_write,      // 1 read
    output logic             advance_or_load,     // 1 advance
    output logic             select_low_a,        // select, low
    output logic             select_high,         // select, high
    output logic             select_low_b,        // select, low
    output logic [3:0]       byte_write_strobe_n, // lane strobes, low
    output logic             clock_enable_n,      // edge enable, low
    output logic [31:0]      data_in              // write data
);
    logic        load_w;
    logic        wr_reg;
    logic        tog_reg;
    logic [31:0] w1_reg;
    logic [2:0]  sel_off_w;
    assign load_w = (cmd_kind == 3'h1) || (cmd_kind == 3'h2);
    assign address         = load_w ? cmd_addr : ~cmd_addr;
    assign read_not_write  = load_w ? (cmd_kind == 3'h1) : tog_reg;
    assign advance_or_load = (cmd_kind == 3'h3);
    assign sel_off_w       = (cmd_kind == 3'h0) ? (3'h1 << cmd_addr[1:0]) : 3'h0;
    assign select_low_a    = sel_off_w[0];
    assign select_high     = ~sel_off_w[1];
    assign select_low_b    = sel_off_w[2];
    assign byte_write_strobe_n = (cmd_kind == 3'h2 || cmd_kind == 3'h3) ? 4'h0 : 4'hF;
    assign clock_enable_n  = (cmd_kind == 3'h4);
    always @(posedge ref_clk) begin
        tog_reg <= nrst & ~tog_reg;
        if (!nrst) begin
            wr_reg <= 1'b0;
            data_in <= 32'h0;
        end else if (!clock_enable_n) begin
            wr_reg <= (cmd_kind == 3'h2) || (cmd_kind == 3'h3 && wr_reg);
            w1_reg <= cmd_wdata;
            data_in <= wr_reg ? w1_reg : ~data_in;
        end
    end
endmodule : spsb_ctrl_model

// [tb/sync_pipelined_sram_burst_test.sv]
// Purpose: self-checking bench for the pipelined burst memory
// Assumes: one memory command per cycle; APB used while pins idle
// Notes:   shadow array and three-entry pipe predict each output
`timescale 1ns/1ps
module sync_pipelined_sram_burst_test;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        order = 1'b0;
    logic        oe_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0]  k = 3'h0;
    logic [5:0]  ca = 6'h00;
    logic [31:0] cw = 32'h0;
    logic [5:0]  address;
    logic        rnw, adv, sla, shi, slb, cen_n, data_oe, pready, pslverr, cap_rdy;
    logic [3:0]  bws_n;
    logic [31:0] data_in, data_out, prdata, rd;
    logic [31:0] mem [64];
    logic [39:0] pe [3] = '{40'h0, 40'h0, 40'h0};
    logic [39:0] ne = 40'h0;
    logic        er, bwr, bopen = 1'b0, run = 1'b1, lsusp = 1'b0;
    logic [5:0]  base;
    logic [1:0]  bk;
    int          n_fail = 0, samples_checked = 0, i, j;

    always #12.5 ref_clk = ~ref_clk;

    spsb_core dut (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .address(address),
        .read_not_write(rnw), .advance_or_load(adv), .select_low_a(sla), .select_high(shi),
        .select_low_b(slb), .byte_write_strobe_n(bws_n), .clock_enable_n(cen_n),
        .burst_order_select(order), .output_enable_n(oe_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_ready(cap_rdy));
    spsb_ctrl_model pm (.ref_clk(ref_clk), .nrst(nrst), .cmd_kind(k), .cmd_addr(ca),
        .cmd_wdata(cw), .address(address), .read_not_write(rnw), .advance_or_load(adv),
        .select_low_a(sla), .select_high(shi), .select_low_b(slb),
        .byte_write_strobe_n(bws_n), .clock_enable_n(cen_n), .data_in(data_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_w

    task automatic chk_b(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_b

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // one memory command; entered and left at a rising edge
    task automatic cyc(input logic [2:0] kk, input logic [5:0] aa, input logic [31:0] ww);
        if (!lsusp) begin
            pe[2] = pe[1];
            pe[1] = pe[0];
            pe[0] = ne;
        end
        if (kk == 3'h0 || ((kk == 3'h1 || kk == 3'h2) && !run)) bopen = 1'b0;
        else if (kk == 3'h1 || kk == 3'h2) begin
            bopen = 1'b1;
            bwr = (kk == 3'h2);
            base = aa;
            bk = 2'h0;
        end else if (kk == 3'h3 && bopen) bk = bk + 2'h1;
        ne = 40'h0;
        if (bopen && kk != 3'h0 && kk != 3'h4)
            ne = {bwr ? 2'h2 : 2'h1, base[5:2], order ? base[1:0] ^ bk : base[1:0] + bk, ww};
        lsusp = (kk == 3'h4);
        k <= kk;
        ca <= aa;
        cw <= ww;
        @(negedge ref_clk);
        if (pe[2][39:38] == 2'h1) begin
            chk_w("read word", mem[pe[2][37:32]], data_out);
            chk_b("drive on", ~oe_n, data_oe);
        end else chk_b("drive off", 1'b0, data_oe);
        if (pe[1][39:38] == 2'h2) mem[pe[1][37:32]] = pe[1][31:0];
        @(posedge ref_clk);
    endtask : cyc

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, 12'h000, 32'h0, rd, er);
        chk_w("ctrl reset", 32'h1, rd);
        for (i = 0; i < 4; i++) begin
            order <= i[1];
            cyc(3'h0, 6'h0, 32'h0);
            cyc(3'h2, 6'(i * 4 + 1), 32'(32'hC0DE0000 + i * 16));
            for (j = 0; j < 3; j++) cyc(3'h3, 6'h3F, 32'(32'hC0DE0001 + i * 16 + j));
        end
        $display("test burst write done");
        for (i = 0; i < 2; i++) begin
            order <= i[0];
            cyc(3'h0, 6'h0, 32'h0);
            cyc(3'h1, 6'(4 * i + 2), 32'h0);
            for (j = 0; j < 4; j++) cyc(3'h3, 6'h3F, 32'h0);
            cyc(3'h1, 6'h0B, 32'h0);
            for (j = 0; j < 5; j++) cyc(3'h3, 6'h3F, 32'h0);
            cyc(3'h2, 6'h14, 32'hBEEF0000);
            cyc(3'h1, 6'h05, 32'h0);
            cyc(3'h0, 6'h2, 32'h0);
            cyc(3'h3, 6'h3F, 32'h0);
            cyc(3'h1, 6'h0E, 32'h0);
            cyc(3'h0, 6'h0, 32'h0);
            cyc(3'h0, 6'h1, 32'h0);
            cyc(3'h0, 6'h1, 32'h0);
        end
        $display("test burst read done");
        cyc(3'h1, 6'h07, 32'h0);
        cyc(3'h4, 6'h3F, 32'h0);
        cyc(3'h3, 6'h3F, 32'h0);
        cyc(3'h4, 6'h3F, 32'h0);
        cyc(3'h4, 6'h3F, 32'h0);
        cyc(3'h2, 6'h16, 32'h5EED0000);
        cyc(3'h4, 6'h3F, 32'h0);
        cyc(3'h3, 6'h3F, 32'h5EED0001);
        cyc(3'h0, 6'h0, 32'h0);
        cyc(3'h1, 6'h16, 32'h0);
        cyc(3'h3, 6'h3F, 32'h0);
        for (j = 0; j < 3; j++) cyc(3'h0, 6'h0, 32'h0);
        $display("test suspend done");
        oe_n <= 1'b1;
        cyc(3'h1, 6'h03, 32'h0);
        for (j = 0; j < 3; j++) cyc(3'h3, 6'h3F, 32'h0);
        oe_n <= 1'b0;
        for (j = 0; j < 3; j++) cyc(3'h0, 6'h0, 32'h0);
        $display("test output gate done");
        apb(1'b0, 12'h00C, 32'h0, rd, er);
        chk_b("unmapped err", 1'b1, er);
        chk_w("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h000, 32'h3, rd, er);
        apb(1'b0, 12'h000, 32'h0, rd, er);
        chk_w("ctrl", 32'h3, rd);
        order <= 1'b0;
        cyc(3'h0, 6'h0, 32'h0);
        cyc(3'h1, 6'h00, 32'h0);
        for (j = 0; j < 19; j++) cyc(3'h3, 6'h3F, 32'h0);
        for (j = 0; j < 3; j++) cyc(3'h0, 6'h0, 32'h0);
        chk_b("fifo full", 1'b0, cap_rdy);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        chk_w("fifo level", 32'h10, (rd >> 4) & 32'h1F);
        for (j = 0; j < 16; j++) begin
            apb(1'b0, 12'h008, 32'h0, rd, er);
            chk_w("fifo word", mem[j % 4], rd);
        end
        apb(1'b0, 12'h008, 32'h0, rd, er);
        chk_w("fifo empty", 32'h0, rd);
        @(negedge ref_clk);
        chk_b("fifo space", 1'b1, cap_rdy);
        @(posedge ref_clk);
        $display("test capture done");
        apb(1'b1, 12'h000, 32'h0, rd, er);
        run = 1'b0;
        cyc(3'h1, 6'h01, 32'h0);
        cyc(3'h3, 6'h3F, 32'h0);
        for (j = 0; j < 3; j++) cyc(3'h0, 6'h0, 32'h0);
        $display("test stopped done");
        give_verdict();
    end
endmodule : sync_pipelined_sram_burst_test
